// *** include/ssc_defs.svh ***
// Register indices, reset values and field widths of the setup register bank
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH
`define SSC_IDX_TPIX 12'h301
`define SSC_IDX_TSYS 12'h303
`define SSC_IDX_TPRE 12'h304
`define SSC_IDX_OPRE 12'h305
`define SSC_IDX_TMPH 12'h306
`define SSC_IDX_TMPL 12'h307
`define SSC_IDX_OPIX 12'h309
`define SSC_IDX_OSYS 12'h30B
`define SSC_IDX_OMPH 12'h30C
`define SSC_IDX_OMPL 12'h30D
`define SSC_IDX_TRIG 12'h320
`define SSC_IDX_STAT 12'h321
`define SSC_IDX_TDIV 12'h322
`define SSC_IDX_PEN 12'h324
`define SSC_IDX_MODE 12'h32E
`define SSC_IDX_REF 12'h32F
`define SSC_IDX_SPH 12'h330
`define SSC_IDX_SPL 12'h331
`define SSC_IDX_DLH 12'h332
`define SSC_IDX_DLL 12'h333
`define SSC_IDX_ONH 12'h334
`define SSC_IDX_ONL 12'h335
`define SSC_IDX_OFH 12'h336
`define SSC_IDX_OFL 12'h337
`define SSC_IDX_CNT 12'h338
`define SSC_IDX_XEV 12'h381
`define SSC_IDX_YEV 12'h383
`define SSC_RST_TPIX 5'h05
`define SSC_RST_TSYS 2'h1
`define SSC_RST_PRE 8'h02
`define SSC_RST_MPY 11'h075
`define SSC_RST_OPIX 5'h0A
`define SSC_RST_OSYS 2'h1
`define SSC_RST_TDIV 8'h01
`define SSC_RST_SP 16'h0000
`define SSC_RST_DL 16'h0000
`define SSC_RST_ON 16'h0001
`define SSC_RST_OFF 16'h0001
`define SSC_RST_CNT 8'h01
`define SSC_EVEN_STEP 3'h1
`define SSC_MODE_SINGLE 2'h0
`define SSC_MODE_CONT 2'h1
`define SSC_MODE_VCNT 2'h2
`define SSC_SHUTTER_ROLLING 1'b0
`endif

// *** include/ssc_pkg.sv ***
// Types of the setup register bank
package ssc_pkg;
	typedef enum logic [2:0] {
		SSC_ST_IDLE = 3'b000,
		SSC_ST_WAIT = 3'b001,
		SSC_ST_DELAY = 3'b010,
		SSC_ST_HIGH = 3'b011,
		SSC_ST_LOW = 3'b100
	} ssc_state_t;
endpackage

// *** hw/ssc_regs.sv ***
// Clock setup and flash strobe register bank with APB slave
`timescale 1ns/10ps
`include "ssc_defs.svh"
module ssc_regs import ssc_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [15:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	input wire logic i_vsync,
	input wire logic i_exposure_start,
	input wire logic i_readout_start,
	input wire logic [15:0] i_vcnt,
	input wire logic i_shutter_mode,
	output logic [4:0] o_timing_pixel_clock_divider,
	output logic [1:0] o_timing_system_clock_divider,
	output logic [7:0] o_timing_pre_pll_divider,
	output logic [10:0] o_timing_pll_multiplier,
	output logic [4:0] o_output_pixel_clock_divider,
	output logic [1:0] o_output_system_clock_divider,
	output logic [7:0] o_output_pre_pll_divider,
	output logic [10:0] o_output_pll_multiplier,
	output logic o_strobe
);
	// Register storage
	logic [4:0] tpix_r;
	logic [1:0] tsys_r;
	logic [7:0] tpre_r;
	logic [7:0] opre_r;
	logic [10:0] tmpy_r;
	logic [4:0] opix_r;
	logic [1:0] osys_r;
	logic [10:0] ompy_r;
	logic trig_r;
	logic [7:0] tdiv_r;
	logic [1:0] pen_r;
	logic [1:0] mode_r;
	logic ref_r;
	logic [15:0] sp_r;
	logic [15:0] dl_r;
	logic [15:0] on_r;
	logic [15:0] off_r;
	logic [7:0] cnt_r;
	// Pin synchronisers
	logic [2:0] vs_r;
	logic [2:0] ex_r;
	logic [2:0] ro_r;
	// Strobe engine
	ssc_state_t st_r;
	ssc_state_t st_nxt;
	logic [7:0] tick_cnt_r;
	logic [15:0] tcnt_r;
	logic [7:0] pcnt_r;
	logic strobe_nxt;
	// APB decode
	wire [11:0] idx = i_paddr[13:2];
	wire setup = i_psel && !i_penable && !o_pready;
	wire done_acc = i_psel && i_penable && o_pready;
	wire wr = done_acc && i_pwrite;
	wire [7:0] wd = i_pwdata[7:0];
	wire aligned = (i_paddr[1:0] == 2'h0) && (i_paddr[15:14] == 2'h0);
	wire hit_tpix = aligned && (idx == `SSC_IDX_TPIX);
	wire hit_tsys = aligned && (idx == `SSC_IDX_TSYS);
	wire hit_tpre = aligned && (idx == `SSC_IDX_TPRE);
	wire hit_opre = aligned && (idx == `SSC_IDX_OPRE);
	wire hit_tmph = aligned && (idx == `SSC_IDX_TMPH);
	wire hit_tmpl = aligned && (idx == `SSC_IDX_TMPL);
	wire hit_opix = aligned && (idx == `SSC_IDX_OPIX);
	wire hit_osys = aligned && (idx == `SSC_IDX_OSYS);
	wire hit_omph = aligned && (idx == `SSC_IDX_OMPH);
	wire hit_ompl = aligned && (idx == `SSC_IDX_OMPL);
	wire hit_trig = aligned && (idx == `SSC_IDX_TRIG);
	wire hit_stat = aligned && (idx == `SSC_IDX_STAT);
	wire hit_tdiv = aligned && (idx == `SSC_IDX_TDIV);
	wire hit_pen = aligned && (idx == `SSC_IDX_PEN);
	wire hit_mode = aligned && (idx == `SSC_IDX_MODE);
	wire hit_ref = aligned && (idx == `SSC_IDX_REF);
	wire hit_sph = aligned && (idx == `SSC_IDX_SPH);
	wire hit_spl = aligned && (idx == `SSC_IDX_SPL);
	wire hit_dlh = aligned && (idx == `SSC_IDX_DLH);
	wire hit_dll = aligned && (idx == `SSC_IDX_DLL);
	wire hit_onh = aligned && (idx == `SSC_IDX_ONH);
	wire hit_onl = aligned && (idx == `SSC_IDX_ONL);
	wire hit_ofh = aligned && (idx == `SSC_IDX_OFH);
	wire hit_ofl = aligned && (idx == `SSC_IDX_OFL);
	wire hit_cnt = aligned && (idx == `SSC_IDX_CNT);
	wire hit_xev = aligned && (idx == `SSC_IDX_XEV);
	wire hit_yev = aligned && (idx == `SSC_IDX_YEV);
	wire busy = (st_r != SSC_ST_IDLE);
	// Read mux
	wire [7:0] rd_byte =
		hit_tpix ? {3'h0, tpix_r} :
		hit_tsys ? {6'h00, tsys_r} :
		hit_tpre ? tpre_r :
		hit_opre ? opre_r :
		hit_tmph ? {5'h00, tmpy_r[10:8]} :
		hit_tmpl ? tmpy_r[7:0] :
		hit_opix ? {3'h0, opix_r} :
		hit_osys ? {6'h00, osys_r} :
		hit_omph ? {5'h00, ompy_r[10:8]} :
		hit_ompl ? ompy_r[7:0] :
		hit_trig ? {7'h00, trig_r} :
		hit_stat ? {7'h00, busy} :
		hit_tdiv ? tdiv_r :
		hit_pen ? {7'h00, pen_r[0]} :
		hit_mode ? {6'h00, mode_r} :
		hit_ref ? {7'h00, ref_r} :
		hit_sph ? sp_r[15:8] :
		hit_spl ? sp_r[7:0] :
		hit_dlh ? dl_r[15:8] :
		hit_dll ? dl_r[7:0] :
		hit_onh ? on_r[15:8] :
		hit_onl ? on_r[7:0] :
		hit_ofh ? off_r[15:8] :
		hit_ofl ? off_r[7:0] :
		hit_cnt ? cnt_r :
		(hit_xev || hit_yev) ? {5'h00, `SSC_EVEN_STEP} :
		8'h00;
	wire mapped = hit_tpix || hit_tsys || hit_tpre || hit_opre || hit_tmph || hit_tmpl || hit_opix
		|| hit_osys || hit_omph || hit_ompl || hit_trig || hit_stat || hit_tdiv || hit_pen || hit_mode
		|| hit_ref || hit_sph || hit_spl || hit_dlh || hit_dll || hit_onh || hit_onl || hit_ofh
		|| hit_ofl || hit_cnt || hit_xev || hit_yev;
	// Pin edges, read only after the second flop
	wire vs_rise = vs_r[1] && !vs_r[2];
	wire ex_rise = ex_r[1] && !ex_r[2];
	wire ro_rise = ro_r[1] && !ro_r[2];
	// Strobe timing
	wire tick = ({1'b0, tick_cnt_r} + 9'h001) >= {1'b0, tdiv_r};
	wire rolling = (i_shutter_mode == `SSC_SHUTTER_ROLLING);
	wire shutter_ev = ref_r ? ro_rise : ex_rise;
	wire ref_ev = (mode_r == `SSC_MODE_VCNT) ? (i_vcnt == sp_r) : shutter_ev;
	wire start = wr && hit_trig && wd[0] && pen_r[0] && rolling;
	wire last_pulse = ({1'b0, pcnt_r} + 9'h001) >= {1'b0, cnt_r};
	wire seq_end = (st_r == SSC_ST_HIGH) && (tcnt_r >= on_r) && last_pulse;
	wire again = (mode_r == `SSC_MODE_CONT) && trig_r;
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			SSC_ST_IDLE: begin
				if (start) begin
					st_nxt = SSC_ST_WAIT;
				end
			end
			SSC_ST_WAIT: begin
				if (ref_ev) begin
					st_nxt = SSC_ST_DELAY;
				end
			end
			SSC_ST_DELAY: begin
				if (tcnt_r >= dl_r) begin
					st_nxt = SSC_ST_HIGH;
				end
			end
			SSC_ST_HIGH: begin
				if (tcnt_r >= on_r) begin
					st_nxt = last_pulse ? (again ? SSC_ST_WAIT : SSC_ST_IDLE) : SSC_ST_LOW;
				end
			end
			SSC_ST_LOW: begin
				if (tcnt_r >= off_r) begin
					st_nxt = SSC_ST_HIGH;
				end
			end
			default: begin
				st_nxt = SSC_ST_IDLE;
			end
		endcase
		if (!rolling || !pen_r[0]) begin
			st_nxt = SSC_ST_IDLE;
		end
	end
	assign strobe_nxt = (st_nxt == SSC_ST_HIGH) && pen_r[0] && rolling;
	// APB answer, no wait states
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_pready <= 1'b0;
			o_prdata <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= setup;
			o_prdata <= (setup && !i_pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
			o_pslverr <= setup && !mapped;
		end
	end
	// Software writes
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			tpix_r <= `SSC_RST_TPIX;
			tsys_r <= `SSC_RST_TSYS;
			tpre_r <= `SSC_RST_PRE;
			opre_r <= `SSC_RST_PRE;
			tmpy_r <= `SSC_RST_MPY;
			opix_r <= `SSC_RST_OPIX;
			osys_r <= `SSC_RST_OSYS;
			ompy_r <= `SSC_RST_MPY;
			tdiv_r <= `SSC_RST_TDIV;
			pen_r <= 2'h0;
			mode_r <= `SSC_MODE_SINGLE;
			ref_r <= 1'b0;
			sp_r <= `SSC_RST_SP;
			dl_r <= `SSC_RST_DL;
			on_r <= `SSC_RST_ON;
			off_r <= `SSC_RST_OFF;
			cnt_r <= `SSC_RST_CNT;
		end else if (wr) begin
			if (hit_tpix) tpix_r <= wd[4:0];
			if (hit_tsys) tsys_r <= wd[1:0];
			if (hit_tpre) tpre_r <= wd;
			if (hit_opre) opre_r <= wd;
			if (hit_tmph) tmpy_r[10:8] <= wd[2:0];
			if (hit_tmpl) tmpy_r[7:0] <= wd;
			if (hit_opix) opix_r <= wd[4:0];
			if (hit_osys) osys_r <= wd[1:0];
			if (hit_omph) ompy_r[10:8] <= wd[2:0];
			if (hit_ompl) ompy_r[7:0] <= wd;
			if (hit_tdiv) tdiv_r <= wd;
			if (hit_pen) pen_r <= {1'b0, wd[0]};
			if (hit_mode) mode_r <= wd[1:0];
			if (hit_ref) ref_r <= wd[0];
			if (hit_sph) sp_r[15:8] <= wd;
			if (hit_spl) sp_r[7:0] <= wd;
			if (hit_dlh) dl_r[15:8] <= wd;
			if (hit_dll) dl_r[7:0] <= wd;
			if (hit_onh) on_r[15:8] <= wd;
			if (hit_onl) on_r[7:0] <= wd;
			if (hit_ofh) off_r[15:8] <= wd;
			if (hit_ofl) off_r[7:0] <= wd;
			if (hit_cnt) cnt_r <= wd;
		end
	end
	// Trigger bit: software write wins over end-of-sequence clear
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			trig_r <= 1'b0;
		end else if (wr && hit_trig) begin
			trig_r <= wd[0];
		end else if (seq_end && !again) begin
			trig_r <= 1'b0;
		end
	end
	// Synchronisers
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			vs_r <= 3'h0;
			ex_r <= 3'h0;
			ro_r <= 3'h0;
		end else begin
			vs_r <= {vs_r[1:0], i_vsync};
			ex_r <= {ex_r[1:0], i_exposure_start};
			ro_r <= {ro_r[1:0], i_readout_start};
		end
	end
	// Clock settings out; PLL side retimed at vertical sync
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_timing_pixel_clock_divider <= `SSC_RST_TPIX;
			o_timing_system_clock_divider <= `SSC_RST_TSYS;
			o_output_pixel_clock_divider <= `SSC_RST_OPIX;
			o_output_system_clock_divider <= `SSC_RST_OSYS;
			o_timing_pre_pll_divider <= `SSC_RST_PRE;
			o_output_pre_pll_divider <= `SSC_RST_PRE;
			o_timing_pll_multiplier <= `SSC_RST_MPY;
			o_output_pll_multiplier <= `SSC_RST_MPY;
		end else begin
			o_timing_pixel_clock_divider <= tpix_r;
			o_timing_system_clock_divider <= tsys_r;
			o_output_pixel_clock_divider <= opix_r;
			o_output_system_clock_divider <= osys_r;
			if (vs_rise) begin
				o_timing_pre_pll_divider <= tpre_r;
				o_output_pre_pll_divider <= opre_r;
				o_timing_pll_multiplier <= tmpy_r;
				o_output_pll_multiplier <= ompy_r;
			end
		end
	end
	// Strobe engine
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			st_r <= SSC_ST_IDLE;
			tick_cnt_r <= 8'h00;
			tcnt_r <= 16'h0000;
			pcnt_r <= 8'h00;
			o_strobe <= 1'b0;
		end else begin
			st_r <= st_nxt;
			o_strobe <= strobe_nxt;
			tick_cnt_r <= (tick || st_nxt != st_r) ? 8'h00 : tick_cnt_r + 8'h01;
			if (st_nxt != st_r) begin
				tcnt_r <= 16'h0000;
			end else if (tick && tcnt_r != 16'hFFFF) begin
				tcnt_r <= tcnt_r + 16'h0001;
			end
			if (st_nxt == SSC_ST_IDLE || st_nxt == SSC_ST_WAIT) begin
				pcnt_r <= 8'h00;
			end else if (st_r == SSC_ST_HIGH && st_nxt == SSC_ST_LOW) begin
				pcnt_r <= pcnt_r + 8'h01;
			end
		end
	end
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	AST_TPIX_WRITE: assert property (wr && hit_tpix |=> ##1 o_timing_pixel_clock_divider == $past(wd[4:0], 2))
		else $error("timing pixel divider not applied");
	AST_TSYS_WRITE: assert property (wr && hit_tsys |=> ##1 o_timing_system_clock_divider == $past(wd[1:0], 2))
		else $error("timing system divider not applied");
	AST_PRE_HOLD: assert property (!vs_rise |=> $stable(o_timing_pre_pll_divider))
		else $error("timing pre-PLL divider changed outside vsync");
	AST_OPRE_VS: assert property (vs_rise |=> o_output_pre_pll_divider == $past(opre_r))
		else $error("output pre-PLL divider not taken at vsync");
	AST_TMPY_VS: assert property (vs_rise |=> o_timing_pll_multiplier == $past(tmpy_r))
		else $error("timing multiplier not taken at vsync");
	AST_OMPY_HOLD: assert property (!vs_rise |=> $stable(o_output_pll_multiplier))
		else $error("output multiplier changed outside vsync");
	AST_TRIG_START: assert property (st_r == SSC_ST_IDLE && start |=> st_r == SSC_ST_WAIT ##0 busy)
		else $error("trigger did not start sequence");
	AST_STROBE_GATE: assert property (o_strobe |-> $past(pen_r[0]) && $past(st_nxt) == SSC_ST_HIGH)
		else $error("strobe driven while disabled");
	AST_TICK_DIV: assert property (tick && tdiv_r > 8'h01 && !(wr && hit_tdiv) |=> !tick)
		else $error("strobe tick faster than divider");
	AST_DELAY_WAIT: assert property (st_r == SSC_ST_DELAY && tcnt_r < dl_r |=> st_r != SSC_ST_HIGH)
		else $error("strobe asserted before delay");
	AST_EVEN_READ: assert property (done_acc && !i_pwrite && (hit_xev || hit_yev) |-> o_prdata == 32'h0000_0001)
		else $error("even step not read as one");
	AST_STATUS_END: assert property (seq_end && !again && rolling && pen_r[0] |=> !busy)
		else $error("status stays busy after last pulse");
	AST_RS_ONLY: assert property (!rolling |=> !o_strobe)
		else $error("strobe outside rolling shutter mode");
	COV_PULSE: cover property (st_r == SSC_ST_HIGH ##1 st_r == SSC_ST_LOW);
	COV_DONE: cover property (busy ##1 !busy);
	COV_CONT: cover property (st_r == SSC_ST_HIGH && again ##1 st_r == SSC_ST_WAIT);
endmodule

// *** verification/ssc_host.sv ***
// Host-side APB master model for the setup register bank
`timescale 1ns/10ps
module ssc_host (
	input wire logic i_clk,
	input wire logic i_pready,
	input wire logic [31:0] i_prdata,
	input wire logic i_pslverr,
	output logic o_psel,
	output logic o_penable,
	output logic o_pwrite,
	output logic [15:0] o_paddr,
	output logic [31:0] o_pwdata
);
	int hangs = 0;
	initial begin
		o_psel = 1'b0;
		o_penable = 1'b0;
		o_pwrite = 1'b0;
		o_paddr = 16'h0000;
		o_pwdata = 32'h0000_0000;
	end
	// One transfer: setup, access until pready, then release
	task automatic xfer(input logic w, input logic [11:0] idx, input logic [7:0] wd,
		output logic [7:0] rd, output logic err);
		int n;
		@(posedge i_clk);
		o_psel <= 1'b1;
		o_pwrite <= w;
		o_paddr <= {2'b00, idx, 2'b00};
		o_pwdata <= {24'h00_0000, wd};
		@(posedge i_clk);
		o_penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (i_pready !== 1'b1 && n < 16);
		if (i_pready !== 1'b1) hangs++;
		rd = i_prdata[7:0];
		err = i_pslverr;
		o_psel <= 1'b0;
		o_penable <= 1'b0;
		// Released lines no longer show the last value
		o_paddr <= ~o_paddr;
		o_pwdata <= ~o_pwdata;
	endtask
endmodule

// *** verification/tb_top.sv ***
// Self-checking testbench of the setup register bank
`timescale 1ns/10ps
`include "ssc_defs.svh"
module tb_top;
	logic i_clk, i_rst_n, i_vsync, i_exposure_start, i_readout_start, i_shutter_mode;
	logic [15:0] i_vcnt, paddr;
	logic psel, penable, pwrite, pready, pslverr, o_strobe;
	logic [31:0] pwdata, prdata;
	logic [4:0] o_timing_pixel_clock_divider, o_output_pixel_clock_divider;
	logic [1:0] o_timing_system_clock_divider, o_output_system_clock_divider;
	logic [7:0] o_timing_pre_pll_divider, o_output_pre_pll_divider;
	logic [10:0] o_timing_pll_multiplier, o_output_pll_multiplier;
	int n_errors = 0;
	int samples_checked = 0;
	int on_clks = 3;
	logic [19:0] rst_tab [27] = '{20'h3_0105, 20'h3_0301, 20'h3_0402, 20'h3_0502, 20'h3_0600, 20'h3_0775,
		20'h3_090A, 20'h3_0B01, 20'h3_0C00, 20'h3_0D75, 20'h3_2000, 20'h3_2100, 20'h3_2201, 20'h3_2400,
		20'h3_2E00, 20'h3_2F00, 20'h3_3000, 20'h3_3100, 20'h3_3200, 20'h3_3300, 20'h3_3400, 20'h3_3501,
		20'h3_3600, 20'h3_3701, 20'h3_3801, 20'h3_8101, 20'h3_8301};
	ssc_host u_host (.i_clk(i_clk), .i_pready(pready), .i_prdata(prdata), .i_pslverr(pslverr), .o_psel(psel),
		.o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata));
	ssc_regs u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
		.i_vsync(i_vsync), .i_exposure_start(i_exposure_start), .i_readout_start(i_readout_start),
		.i_vcnt(i_vcnt), .i_shutter_mode(i_shutter_mode),
		.o_timing_pixel_clock_divider(o_timing_pixel_clock_divider),
		.o_timing_system_clock_divider(o_timing_system_clock_divider),
		.o_timing_pre_pll_divider(o_timing_pre_pll_divider), .o_timing_pll_multiplier(o_timing_pll_multiplier),
		.o_output_pixel_clock_divider(o_output_pixel_clock_divider),
		.o_output_system_clock_divider(o_output_system_clock_divider),
		.o_output_pre_pll_divider(o_output_pre_pll_divider), .o_output_pll_multiplier(o_output_pll_multiplier),
		.o_strobe(o_strobe));
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		n_errors += u_host.hangs;
		$display("errors=%0d checks=%0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		logic [7:0] d;
		logic e;
		u_host.xfer(1'b1, a, v, d, e);
	endtask
	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		logic e;
		u_host.xfer(1'b0, a, 8'h00, d, e);
	endtask
	task automatic chk_reset;
		logic [7:0] d;
		foreach (rst_tab[k]) begin
			rd(rst_tab[k][19:8], d);
			chk(d, rst_tab[k][7:0]);
		end
		chk({o_timing_pixel_clock_divider, o_timing_system_clock_divider, o_timing_pre_pll_divider,
			o_timing_pll_multiplier}, {5'h05, 2'h1, 8'h02, 11'h075});
		chk({o_output_pixel_clock_divider, o_output_system_clock_divider, o_output_pre_pll_divider,
			o_output_pll_multiplier}, {5'h0A, 2'h1, 8'h02, 11'h075});
	endtask
	task automatic clk_regs;
		logic [7:0] d;
		wr(`SSC_IDX_TPIX, 8'h1F);
		wr(`SSC_IDX_TSYS, 8'h03);
		wr(`SSC_IDX_OPIX, 8'h11);
		wr(`SSC_IDX_OSYS, 8'h02);
		wr(`SSC_IDX_TPRE, 8'h03);
		wr(`SSC_IDX_OPRE, 8'h01);
		wr(`SSC_IDX_TMPH, 8'hFF);
		wr(`SSC_IDX_TMPL, 8'hFF);
		wr(`SSC_IDX_OMPH, 8'h02);
		wr(`SSC_IDX_OMPL, 8'h34);
		repeat (2) @(negedge i_clk);
		chk({o_timing_pixel_clock_divider, o_timing_system_clock_divider, o_output_pixel_clock_divider,
			o_output_system_clock_divider}, {5'h1F, 2'h3, 5'h11, 2'h2});
		chk({o_timing_pre_pll_divider, o_output_pre_pll_divider}, 16'h0202);
		chk({o_timing_pll_multiplier, o_output_pll_multiplier}, {11'h075, 11'h075});
		rd(`SSC_IDX_TMPH, d);
		chk(d, 8'h07);
		@(posedge i_clk) i_vsync <= 1'b1;
		repeat (6) @(posedge i_clk);
		i_vsync <= 1'b0;
		@(negedge i_clk);
		chk({o_timing_pre_pll_divider, o_output_pre_pll_divider}, 16'h0301);
		chk({o_timing_pll_multiplier, o_output_pll_multiplier}, {11'h7FF, 11'h234});
	endtask
	task automatic bus_err;
		logic [7:0] d;
		logic e;
		u_host.xfer(1'b1, `SSC_IDX_XEV, 8'h05, d, e);
		rd(`SSC_IDX_XEV, d);
		chk(d, 8'h01);
		u_host.xfer(1'b0, 12'h310, 8'h00, d, e);
		chk({e, d}, 9'h100);
	endtask
	// Arms the strobe, fires ne reference events and counts strobe pulses
	task automatic strobe_case(input logic [1:0] mode, input logic refb, input logic [7:0] cnt, input logic en,
		input logic sh, input int ev, input int ne, input int exp);
		logic [7:0] d;
		int t;
		int h;
		logic p;
		t = 0;
		h = 0;
		p = 1'b0;
		wr(`SSC_IDX_PEN, {7'h00, en});
		wr(`SSC_IDX_MODE, {6'h00, mode});
		wr(`SSC_IDX_REF, {7'h00, refb});
		wr(`SSC_IDX_CNT, cnt);
		i_shutter_mode <= sh;
		wr(`SSC_IDX_TRIG, 8'h01);
		rd(`SSC_IDX_STAT, d);
		chk(d, {7'h00, en & ~sh});
		repeat (ne) begin
			@(posedge i_clk);
			if (ev == 0) i_exposure_start <= 1'b1;
			else if (ev == 1) i_readout_start <= 1'b1;
			else i_vcnt <= 16'h0010;
			for (int i = 0; i < 60; i++) begin
				@(posedge i_clk);
				if (i == 4) begin
					i_exposure_start <= 1'b0;
					i_readout_start <= 1'b0;
					i_vcnt <= 16'h0000;
				end
				@(negedge i_clk);
				if (o_strobe === 1'b1 && p !== 1'b1) t++;
				if (o_strobe === 1'b1) h++;
				p = o_strobe;
			end
		end
		chk(t, exp);
		chk(h, exp * on_clks);
		rd(`SSC_IDX_STAT, d);
		chk(d, {7'h00, (mode == 2'h1 || exp == 0) & en & ~sh});
		wr(`SSC_IDX_TRIG, 8'h00);
		wr(`SSC_IDX_PEN, 8'h00);
		i_shutter_mode <= 1'b0;
	endtask
	initial begin
		repeat (100000) @(posedge i_clk);
		n_errors++;
		summarize;
	end
	initial begin
		i_rst_n = 1'b0;
		i_vsync = 1'b0;
		i_exposure_start = 1'b0;
		i_readout_start = 1'b0;
		i_shutter_mode = 1'b0;
		i_vcnt = 16'h0000;
		repeat (8) @(posedge i_clk);
		i_rst_n <= 1'b1;
		chk_reset;
		clk_regs;
		bus_err;
		wr(`SSC_IDX_ONL, 8'h02);
		wr(`SSC_IDX_SPL, 8'h10);
		strobe_case(2'h0, 1'b0, 8'h02, 1'b1, 1'b0, 0, 1, 2);
		strobe_case(2'h0, 1'b1, 8'h01, 1'b1, 1'b0, 0, 1, 0);
		strobe_case(2'h0, 1'b1, 8'h01, 1'b1, 1'b0, 1, 1, 1);
		strobe_case(2'h0, 1'b0, 8'h01, 1'b0, 1'b0, 0, 1, 0);
		strobe_case(2'h0, 1'b0, 8'h01, 1'b1, 1'b1, 0, 1, 0);
		strobe_case(2'h2, 1'b0, 8'h01, 1'b1, 1'b0, 2, 1, 1);
		strobe_case(2'h1, 1'b0, 8'h01, 1'b1, 1'b0, 0, 2, 2);
		wr(`SSC_IDX_TDIV, 8'h02);
		wr(`SSC_IDX_DLL, 8'h03);
		on_clks = 5;
		strobe_case(2'h0, 1'b0, 8'h01, 1'b1, 1'b0, 0, 1, 1);
		summarize;
	end
endmodule
